//--- hdl/adc_pd_ctrl.sv
// Power-down, compensation and conversion-clock control of a serial ADC.
// Assumes an AHB-Lite master on ref_clk and a host serial link on link_clk.
`default_nettype none

module adc_pd_ctrl (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic link_clk,
  input wire logic cs_n,
  input wire logic din,
  input wire logic hw_shutdown_in,
  input wire logic hw_shutdown_float,
  input wire logic [adc_pd_pkg::V_W-1:0] analog_uv,
  output logic hw_powerdown,
  output logic full_powerdown,
  output logic fast_powerdown,
  output logic comp_internal,
  output logic comp_external,
  output logic int_clk_out,
  output logic conv_busy,
  output logic adc_ready,
  output logic pd_mode_bit_hi,
  output logic pd_mode_bit_lo,
  output logic [adc_pd_pkg::CODE_W-1:0] result_code
);
  import adc_pd_pkg::*;

  typedef enum logic [2:0] {ST_HW_PD, ST_WAKE, ST_IDLE, ST_CONV, ST_SW_PD} pd_state_e;

  pd_state_e state;
  logic link_rst_s1, link_rst_s2;
  logic hw_shutdown_in_in_s1, hw_shutdown_in_in_s2, hw_shutdown_in_fl_s1, hw_shutdown_in_fl_s2;
  logic [V_W-1:0] analog_s1, analog_s2;
  logic [7:0] rx_byte_l, rx_byte;
  logic byte_tgl_l, byte_s1, byte_s2, byte_s3;
  logic done_tgl_l, done_s1, done_s2, done_s3;
  logic byte_evt, ext_evt, hw_shutdown_in_low;
  logic ext_ref, clk_ext, conv_ext, pd_req, pd_fast, result_valid;
  logic [7:0] wake_cnt, half_cnt, half_lim;
  logic [3:0] tick_cnt;
  logic half_wrap, int_tick, conv_end;
  logic [CODE_W-1:0] q_code;
  logic acc, dp_wr;
  logic [7:0] dp_addr;

  function automatic logic next_clk_ext(input logic [7:0] b, input logic cur);
    return b[PD1_POS] ? b[PD0_POS] : cur;
  endfunction

  // ****************************************
  // Link domain and crossings
  // ****************************************
  always_ff @(posedge link_clk)
  begin
    link_rst_s1 <= reset;
    link_rst_s2 <= link_rst_s1;
  end

  ctrl_byte_rx u_rx (
    .link_clk(link_clk),
    .link_reset(link_rst_s2),
    .cs_n(cs_n),
    .din(din),
    .ctrl_byte(rx_byte_l),
    .byte_tgl(byte_tgl_l),
    .ext_done_tgl(done_tgl_l)
  );

  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      {byte_s1, byte_s2, byte_s3} <= 3'h0;
      {done_s1, done_s2, done_s3} <= 3'h0;
    end
    else
    begin
      {byte_s1, byte_s2, byte_s3} <= {byte_tgl_l, byte_s1, byte_s2};
      {done_s1, done_s2, done_s3} <= {done_tgl_l, done_s1, done_s2};
    end
  end

  assign byte_evt = byte_s2 ^ byte_s3;
  assign ext_evt = done_s2 ^ done_s3;
  assign rx_byte = rx_byte_l;

  // ****************************************
  // Shutdown pin and analog input retiming
  // ****************************************
  always_ff @(posedge ref_clk)
  begin
    hw_shutdown_in_in_s1 <= hw_shutdown_in;
    hw_shutdown_in_in_s2 <= hw_shutdown_in_in_s1;
    hw_shutdown_in_fl_s1 <= hw_shutdown_float;
    hw_shutdown_in_fl_s2 <= hw_shutdown_in_fl_s1;
    analog_s1 <= analog_uv;
    analog_s2 <= analog_s1;
  end

  assign hw_shutdown_in_low = !hw_shutdown_in_fl_s2 && !hw_shutdown_in_in_s2;

  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      comp_internal <= 1'b0;
      comp_external <= 1'b0;
      hw_powerdown <= 1'b1;
      half_lim <= HALF_SLOW;
    end
    else
    begin
      comp_internal <= hw_shutdown_in_in_s2 && !hw_shutdown_in_fl_s2;
      comp_external <= hw_shutdown_in_fl_s2;
      hw_powerdown <= hw_shutdown_in_low;
      half_lim <= hw_shutdown_in_fl_s2 ? HALF_FAST : HALF_SLOW;
    end
  end

  // ****************************************
  // Mode bits from the control byte
  // ****************************************
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      pd_mode_bit_hi <= MODE_INT_CLK[1];
      pd_mode_bit_lo <= MODE_INT_CLK[0];
      clk_ext <= 1'b0;
      pd_req <= 1'b0;
      pd_fast <= 1'b0;
    end
    else if (byte_evt && !hw_shutdown_in_low)
    begin
      pd_mode_bit_hi <= rx_byte[PD1_POS];
      pd_mode_bit_lo <= rx_byte[PD0_POS];
      clk_ext <= next_clk_ext(rx_byte, clk_ext);
      pd_req <= !rx_byte[PD1_POS];
      pd_fast <= rx_byte[PD0_POS];
    end
  end

  // ****************************************
  // Power state machine
  // ****************************************
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      state <= ST_HW_PD;
      wake_cnt <= 8'h00;
      tick_cnt <= 4'h0;
      conv_ext <= 1'b0;
    end
    else if (hw_shutdown_in_low)
      state <= ST_HW_PD;
    else
    begin
      case (state)
        ST_HW_PD:
        begin
          state <= ST_WAKE;
          wake_cnt <= ext_ref ? WAKE_EXT_CYC : WAKE_INT_CYC;
        end
        ST_WAKE:
        begin
          if (wake_cnt == 8'h01)
            state <= ST_IDLE;
          wake_cnt <= wake_cnt - 8'h01;
        end
        ST_IDLE, ST_SW_PD:
        begin
          if (byte_evt)
          begin
            state <= ST_CONV;
            tick_cnt <= CONV_TICKS;
            conv_ext <= next_clk_ext(rx_byte, clk_ext);
          end
        end
        ST_CONV:
        begin
          if (int_tick)
            tick_cnt <= tick_cnt - 4'h1;
          if (conv_end)
            state <= pd_req ? ST_SW_PD : ST_IDLE;
        end
        default: state <= ST_HW_PD;
      endcase
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      full_powerdown <= 1'b0;
      fast_powerdown <= 1'b0;
      conv_busy <= 1'b0;
      adc_ready <= 1'b0;
    end
    else
    begin
      full_powerdown <= (state == ST_SW_PD) && !pd_fast;
      fast_powerdown <= (state == ST_SW_PD) && pd_fast;
      conv_busy <= state == ST_CONV;
      adc_ready <= (state == ST_IDLE) || (state == ST_CONV) || (state == ST_SW_PD);
    end
  end

  // ****************************************
  // Internal conversion clock
  // ****************************************
  assign half_wrap = half_cnt >= half_lim - 8'h01;
  assign int_tick = half_wrap && !int_clk_out;
  assign conv_end = conv_ext ? ext_evt : (int_tick && tick_cnt == 4'h1);

  always_ff @(posedge ref_clk)
  begin
    if (reset || state != ST_CONV || conv_ext)
    begin
      half_cnt <= 8'h00;
      int_clk_out <= 1'b0;
    end
    else if (half_wrap)
    begin
      half_cnt <= 8'h00;
      int_clk_out <= ~int_clk_out;
    end
    else
      half_cnt <= half_cnt + 8'h01;
  end

  // ****************************************
  // Conversion result
  // ****************************************
  code_quantizer u_quant (
    .level_uv(analog_s2),
    .code(q_code)
  );

  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      result_code <= '0;
      result_valid <= 1'b0;
    end
    else if (state == ST_CONV && conv_end && !hw_shutdown_in_low)
    begin
      result_code <= q_code;
      result_valid <= 1'b1;
    end
  end

  // ****************************************
  // AHB-Lite register slave
  // ****************************************
  function automatic logic [31:0] read_mux(input logic [7:0] a);
    logic [31:0] r;
    r = 32'h0000_0000;
    case (a)
      OFS_CTRL: r[CTRL_EXT_REF_BIT] = ext_ref;
      OFS_STATUS:
      begin
        r[ST_HWPD_BIT] = hw_powerdown;
        r[ST_FULL_POWERDOWN_BIT] = full_powerdown;
        r[ST_FAST_POWERDOWN_BIT] = fast_powerdown;
        r[ST_COMP_INT_BIT] = comp_internal;
        r[ST_COMP_EXT_BIT] = comp_external;
        r[ST_CLK_EXT_BIT] = clk_ext;
        r[ST_BUSY_BIT] = conv_busy;
        r[ST_READY_BIT] = adc_ready;
        r[ST_PD_LO_BIT] = pd_mode_bit_lo;
        r[ST_PD_HI_BIT] = pd_mode_bit_hi;
      end
      OFS_RESULT:
      begin
        r[CODE_W-1:0] = result_code;
        r[RESULT_VALID_BIT] = result_valid;
      end
      default: r = 32'h0000_0000;
    endcase
    return r;
  endfunction

  assign acc = hsel && htrans[1] && hready && hsize == HSIZE_WORD;

  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      dp_wr <= 1'b0;
      dp_addr <= 8'h00;
      hrdata <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
    else
    begin
      dp_wr <= acc && hwrite;
      if (acc)
        dp_addr <= haddr[7:0];
      hrdata <= (acc && !hwrite) ? read_mux(haddr[7:0]) : 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  // Reference choice sets the wake delay
  always_ff @(posedge ref_clk)
  begin
    if (reset)
      ext_ref <= CTRL_EXT_REF_RST;
    else if (dp_wr && dp_addr == OFS_CTRL)
      ext_ref <= hwdata[CTRL_EXT_REF_BIT];
  end

  // ****************************************
  // Assertions
  // ****************************************
  logic [47:0] v2x, lo_x, hi_x;
  assign v2x = 48'(analog_s2) * 48'(2 * CODE_STEPS);
  assign lo_x = (48'(q_code) * 48'h2 - 48'h1) * 48'(VREF_UV);
  assign hi_x = (48'(q_code) * 48'h2 + 48'h1) * 48'(VREF_UV);

  sequence s_wake_ext;
    state == ST_HW_PD && !hw_shutdown_in_low && ext_ref;
  endsequence

  sequence s_conv_done;
    state == ST_CONV && conv_end && !hw_shutdown_in_low;
  endsequence

  property p_hw_abort;
    @(posedge ref_clk) disable iff (reset)
    hw_shutdown_in_low |=> state == ST_HW_PD ##1 !conv_busy;
  endproperty
  a_hw_abort: assert property (p_hw_abort) else $error("conversion not aborted");

  property p_fast_clk;
    @(posedge ref_clk) disable iff (reset)
    hw_shutdown_in_fl_s2 |=> half_lim == HALF_FAST;
  endproperty
  a_fast_clk: assert property (p_fast_clk) else $error("floating rate wrong");

  property p_slow_clk;
    @(posedge ref_clk) disable iff (reset)
    hw_shutdown_in_in_s2 && !hw_shutdown_in_fl_s2 |=> half_lim == HALF_SLOW;
  endproperty
  a_slow_clk: assert property (p_slow_clk) else $error("high rate wrong");

  property p_comp;
    @(posedge ref_clk) disable iff (reset)
    hw_shutdown_in_low |=> !comp_internal && !comp_external;
  endproperty
  a_comp: assert property (p_comp) else $error("compensation while low");

  property p_wake_ext;
    @(posedge ref_clk) disable iff (reset)
    s_wake_ext |=> state == ST_WAKE && wake_cnt == WAKE_EXT_CYC;
  endproperty
  a_wake_ext: assert property (p_wake_ext) else $error("wake count wrong");

  property p_wake_end;
    @(posedge ref_clk) disable iff (reset)
    state == ST_WAKE && wake_cnt == 8'h01 && !hw_shutdown_in_low |=> state == ST_IDLE ##1 adc_ready;
  endproperty
  a_wake_end: assert property (p_wake_end) else $error("not ready after wake");

  property p_decode;
    @(posedge ref_clk) disable iff (reset)
    byte_evt && !hw_shutdown_in_low |=> pd_mode_bit_hi == $past(rx_byte[PD1_POS])
      && pd_mode_bit_lo == $past(rx_byte[PD0_POS]) && pd_req == !$past(rx_byte[PD1_POS]);
  endproperty
  a_decode: assert property (p_decode) else $error("mode bits not decoded");

  property p_full;
    @(posedge ref_clk) disable iff (reset)
    state == ST_SW_PD && !pd_fast |=> full_powerdown && !fast_powerdown;
  endproperty
  a_full: assert property (p_full) else $error("full power-down not shown");

  property p_prec;
    @(posedge ref_clk) disable iff (reset)
    hw_shutdown_in_low && byte_evt |=> state == ST_HW_PD && $stable(pd_mode_bit_hi);
  endproperty
  a_prec: assert property (p_prec) else $error("mode bits beat shutdown");

  property p_finish;
    @(posedge ref_clk) disable iff (reset)
    state == ST_CONV && !conv_end && !hw_shutdown_in_low |=> state == ST_CONV;
  endproperty
  a_finish: assert property (p_finish) else $error("conversion cut short");

  property p_sw_pd;
    @(posedge ref_clk) disable iff (reset)
    s_conv_done ##0 pd_req |=> state == ST_SW_PD;
  endproperty
  a_sw_pd: assert property (p_sw_pd) else $error("no power-down after conversion");

  property p_result;
    @(posedge ref_clk) disable iff (reset)
    s_conv_done |=> result_code == $past(q_code) && result_valid;
  endproperty
  a_result: assert property (p_result) else $error("result not captured");

  property p_quant;
    @(posedge ref_clk) disable iff (reset)
    q_code != 12'h000 && q_code != 12'hFFF |-> v2x >= lo_x && v2x < hi_x;
  endproperty
  a_quant: assert property (p_quant) else $error("code not rounded");
endmodule // adc_pd_ctrl

`default_nettype wire

//--- hdl/code_quantizer.sv
// Straight binary quantiser of an input level given in microvolts.
// Assumes a quasi-static input already retimed into the caller's clock.
`default_nettype none

module code_quantizer #(
  parameter int VREF = adc_pd_pkg::VREF_UV
) (
  input wire logic [adc_pd_pkg::V_W-1:0] level_uv,
  output logic [adc_pd_pkg::CODE_W-1:0] code
);
  import adc_pd_pkg::*;

  logic [47:0] scaled;
  logic [47:0] quot;

  // Rounding puts each transition midway between steps
  always_comb
  begin
    scaled = 48'(level_uv) * 48'(CODE_STEPS) + 48'(VREF / 2);
    quot = scaled / 48'(VREF);
    if (quot > 48'(CODE_STEPS - 1))
      code = CODE_W'(CODE_STEPS - 1);
    else
      code = quot[CODE_W-1:0];
  end
endmodule // code_quantizer

`default_nettype wire

//--- hdl/ctrl_byte_rx.sv
// Serial control-byte receiver running on the host's link clock.
// Assumes link_reset is already synchronous to link_clk.
`default_nettype none

module ctrl_byte_rx (
  input wire logic link_clk,
  input wire logic link_reset,
  input wire logic cs_n,
  input wire logic din,
  output logic [7:0] ctrl_byte,
  output logic byte_tgl,
  output logic ext_done_tgl
);
  import adc_pd_pkg::*;

  logic active;
  logic [2:0] bit_cnt;
  logic [6:0] shift;
  logic byte_end;
  logic [1:0] mode;
  logic ext_mode;
  logic ext_run;
  logic [3:0] ext_cnt;

  assign byte_end = !cs_n && active && (bit_cnt == 3'h7);
  assign mode = {shift[0], din};

  // ****************************************
  // Start bit and byte framing
  // ****************************************
  always_ff @(posedge link_clk)
  begin
    if (link_reset || cs_n)
    begin
      active <= 1'b0;
      bit_cnt <= 3'h0;
      shift <= 7'h00;
    end
    else if (!active)
    begin
      if (din)
      begin
        active <= 1'b1;
        bit_cnt <= 3'h1;
        shift <= 7'h01;
      end
    end
    else
    begin
      shift <= {shift[5:0], din};
      bit_cnt <= bit_cnt + 3'h1;
      if (bit_end_q())
        active <= 1'b0;
    end
  end

  function automatic logic bit_end_q();
    return bit_cnt == 3'h7;
  endfunction

  // Byte is held stable until the next one, so the toggle covers it
  always_ff @(posedge link_clk)
  begin
    if (link_reset)
    begin
      ctrl_byte <= 8'h00;
      byte_tgl <= 1'b0;
    end
    else if (byte_end)
    begin
      ctrl_byte <= {shift, din};
      byte_tgl <= ~byte_tgl;
    end
  end

  // ****************************************
  // External clock mode conversion steps
  // ****************************************
  always_ff @(posedge link_clk)
  begin
    if (link_reset)
    begin
      ext_mode <= 1'b0;
      ext_run <= 1'b0;
      ext_cnt <= 4'h0;
      ext_done_tgl <= 1'b0;
    end
    else if (byte_end)
    begin
      if (mode[1])
        ext_mode <= mode[0];
      ext_run <= mode[1] ? mode[0] : ext_mode;
      ext_cnt <= EXT_TICKS;
    end
    else if (ext_run)
    begin
      if (ext_cnt == 4'h1)
      begin
        ext_run <= 1'b0;
        ext_done_tgl <= ~ext_done_tgl;
      end
      ext_cnt <= ext_cnt - 4'h1;
    end
  end
endmodule // ctrl_byte_rx

`default_nettype wire

//--- shared/adc_pd_pkg.sv
// Constants for the converter power-down and clock-mode control block.
// Assumes a 40 MHz reference clock and a serial link clocked by the host.
`default_nettype none

package adc_pd_pkg;
  // ****************************************
  // Clocks and derived cycle counts
  // ****************************************
  localparam int REF_CLK_HZ = 40000000;
  localparam int INT_CLK_FAST_HZ = 1800000;
  localparam int INT_CLK_SLOW_HZ = 225000;
  localparam logic [7:0] HALF_FAST = 8'(REF_CLK_HZ / (2 * INT_CLK_FAST_HZ));
  localparam logic [7:0] HALF_SLOW = 8'(REF_CLK_HZ / (2 * INT_CLK_SLOW_HZ));
  localparam int WAKE_EXT_NS = 2000;
  localparam int WAKE_INT_NS = 5000;
  localparam logic [7:0] WAKE_EXT_CYC = 8'(WAKE_EXT_NS * (REF_CLK_HZ / 1000000) / 1000);
  localparam logic [7:0] WAKE_INT_CYC = 8'(WAKE_INT_NS * (REF_CLK_HZ / 1000000) / 1000);
  localparam logic [3:0] CONV_TICKS = 4'hC;
  localparam logic [3:0] EXT_TICKS = 4'hC;
  // ****************************************
  // Conversion coding
  // ****************************************
  localparam int CODE_W = 12;
  localparam int V_W = 22;
  localparam int CODE_STEPS = 4096;
  localparam int VREF_UV = 2500000;
  // ****************************************
  // Control byte and mode codes
  // ****************************************
  localparam int PD1_POS = 1;
  localparam int PD0_POS = 0;
  localparam logic [1:0] MODE_FULL_PD = 2'h0;
  localparam logic [1:0] MODE_FAST_PD = 2'h1;
  localparam logic [1:0] MODE_INT_CLK = 2'h2;
  localparam logic [1:0] MODE_EXT_CLK = 2'h3;
  // ****************************************
  // Register map
  // ****************************************
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_RESULT = 8'h08;
  localparam logic CTRL_EXT_REF_RST = 1'h0;
  localparam int CTRL_EXT_REF_BIT = 0;
  localparam int ST_HWPD_BIT = 0;
  localparam int ST_FULL_POWERDOWN_BIT = 1;
  localparam int ST_FAST_POWERDOWN_BIT = 2;
  localparam int ST_COMP_INT_BIT = 3;
  localparam int ST_COMP_EXT_BIT = 4;
  localparam int ST_CLK_EXT_BIT = 5;
  localparam int ST_BUSY_BIT = 6;
  localparam int ST_READY_BIT = 7;
  localparam int ST_PD_LO_BIT = 8;
  localparam int ST_PD_HI_BIT = 9;
  localparam int RESULT_VALID_BIT = 15;
  localparam logic [2:0] HSIZE_WORD = 3'h2;
endpackage

`default_nettype wire

//--- verification/link_host_model.sv
// Host serial-port model that sends control bytes on the link.
// Assumes the bench pulses go and waits for busy to fall.
`default_nettype none
module link_host_model (
  input wire logic go,
  input wire logic [7:0] tx_byte,
  input wire logic [4:0] tail,
  output logic busy,
  output logic link_clk,
  output logic cs_n,
  output logic din
);
  timeunit 1ns;
  timeprecision 100ps;
  task automatic tick();
    #7.5 link_clk = 1'b1;
    #7.5 link_clk = 1'b0;
  endtask
  initial
  begin
    {busy, link_clk, cs_n, din} = 4'h3;
  end
  // Clock only inside a frame; tail zeros start no byte
  always @(posedge go)
  begin
    busy = 1'b1;
    cs_n = 1'b0;
    for (int i = 7; i >= 0; i--)
    begin
      din = tx_byte[i];
      tick();
    end
    din = 1'b0;
    repeat (tail) tick();
    cs_n = 1'b1;
    din = 1'b1; // Released line shows the inverse
    busy = 1'b0;
  end
endmodule // link_host_model
`default_nettype wire

//--- verification/tb_adc_power_down_clock_control.sv
// Bench of the converter power-down and clock-mode control.
// Assumes the host model on the link; the bench is the bus master.
`default_nettype none
module tb_adc_power_down_clock_control;
  timeunit 1ns;
  timeprecision 100ps;
  import adc_pd_pkg::*;
  // ****
  // Signals
  // ****
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [31:0] haddr = '0;
  logic [31:0] hwdata = '0;
  logic [1:0] htrans = '0;
  logic [2:0] hsize = HSIZE_WORD;
  logic [31:0] hrdata, rd;
  logic hreadyout, hresp, link_clk, cs_n, din, hbusy;
  logic go = 1'b0;
  logic [7:0] tx_byte = '0;
  logic [4:0] tail = '0;
  logic sd_in = 1'b1;
  logic sd_float = 1'b0;
  logic [V_W-1:0] analog_uv = '0;
  logic hw_powerdown, full_powerdown, fast_powerdown, comp_internal, comp_external;
  logic int_clk_out, conv_busy, adc_ready, pd_mode_bit_hi, pd_mode_bit_lo;
  logic [CODE_W-1:0] result_code;
  logic prev_ic = 1'b0;
  logic [1:0] mseq [4] = '{2'h2, 2'h0, 2'h3, 2'h1};
  int pexp [3] = '{5, 3, 8};
  int vals [5] = '{0, 305, 306, 1250000, 2500000};
  int fail_count = 0;
  int cmp_count = 0;
  int cycles = 0;
  int rises = 0;
  int pdc = 0;
  int hi_run = 0;
  int max_hi = 0;
  int n, r0, p0;
  longint e;
  wire logic [3:0] pins = {hw_powerdown, comp_internal, comp_external, adc_ready};

  always #12.5 ref_clk = ~ref_clk;

  adc_pd_ctrl uut (
    .ref_clk(ref_clk), .reset(reset), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .link_clk(link_clk),
    .cs_n(cs_n), .din(din), .hw_shutdown_in(sd_in), .hw_shutdown_float(sd_float),
    .analog_uv(analog_uv), .hw_powerdown(hw_powerdown), .full_powerdown(full_powerdown),
    .fast_powerdown(fast_powerdown), .comp_internal(comp_internal),
    .comp_external(comp_external), .int_clk_out(int_clk_out), .conv_busy(conv_busy),
    .adc_ready(adc_ready), .pd_mode_bit_hi(pd_mode_bit_hi), .pd_mode_bit_lo(pd_mode_bit_lo),
    .result_code(result_code)
  );

  link_host_model host (
    .go(go), .tx_byte(tx_byte), .tail(tail), .busy(hbusy),
    .link_clk(link_clk), .cs_n(cs_n), .din(din)
  );

  // ****
  // Monitors and tasks
  // ****
  always @(posedge ref_clk)
  begin
    cycles <= cycles + 1;
    prev_ic <= int_clk_out;
    if (int_clk_out === 1'b1 && prev_ic === 1'b0) rises <= rises + 1;
    if (conv_busy === 1'b1 && (full_powerdown | fast_powerdown) !== 1'b0) pdc <= pdc + 1;
    if (int_clk_out === 1'b1) hi_run <= hi_run + 1;
    else if (hi_run != 0)
    begin
      // Longest high phase; the last one of a conversion is cut short
      if (hi_run > max_hi) max_hi <= hi_run;
      hi_run <= 0;
    end
    if (cycles == 20000)
    begin
      fail_count++;
      tally_and_finish();
    end
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= wr;
    @(posedge ref_clk);
    while (hreadyout !== 1'b1) @(posedge ref_clk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge ref_clk);
    while (hreadyout !== 1'b1) @(posedge ref_clk);
    rd = hrdata;
  endtask

  task automatic send(input logic [7:0] b, input logic [4:0] t);
    tx_byte <= b;
    tail <= t;
    go <= 1'b1;
    @(posedge ref_clk);
    go <= 1'b0;
    while (hbusy !== 1'b0) @(posedge ref_clk);
  endtask

  task automatic conv_wait();
    repeat (6) @(posedge ref_clk);
    while (conv_busy !== 1'b0) @(posedge ref_clk);
    repeat (3) @(posedge ref_clk);
  endtask

  task automatic settle();
    repeat (6) @(posedge ref_clk);
    while (adc_ready !== 1'b1) @(posedge ref_clk);
  endtask

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // ****
  // Tests
  // ****
  initial
  begin
    send(8'h00, 5'd0);
    check("reset", 32'({hw_powerdown, pd_mode_bit_hi, pd_mode_bit_lo, hreadyout}), 32'hD);
    reset <= 1'b0;
    send(8'h00, 5'd0); // Link clocks carry the reset release
    settle();
    bus(1'b1, OFS_STATUS, 32'hFFFF);
    bus(1'b0, OFS_STATUS, '0);
    check("status", rd, 32'h288);
    bus(1'b0, 8'h40, '0);
    check("unmapped", rd, '0);
    check("hresp", 32'(hresp), '0);
    bus(1'b0, OFS_CTRL, '0);
    check("ctrl_rst", rd, 32'(CTRL_EXT_REF_RST));
    $display("test registers done");
    for (int i = 0; i < 3; i++)
    begin
      sd_in <= (i == 0);
      sd_float <= (i == 1);
      repeat (6) @(posedge ref_clk);
      check("pins", 32'(pins), 32'(pexp[i]));
    end
    bus(1'b1, OFS_CTRL, 32'h1);
    bus(1'b0, OFS_CTRL, '0);
    check("ctrl", rd, 32'h1);
    sd_in <= 1'b1;
    n = 0;
    while (adc_ready !== 1'b1)
    begin
      @(posedge ref_clk);
      n++;
    end
    check("wake", 32'(n > WAKE_EXT_CYC && n <= WAKE_EXT_CYC + 6), 32'h1);
    $display("test shutdown levels done");
    sd_float <= 1'b1;
    settle();
    foreach (mseq[k])
    begin
      r0 = rises;
      p0 = pdc;
      send({6'h20, mseq[k]}, 5'd14);
      conv_wait();
      check("mode", 32'({pd_mode_bit_hi, pd_mode_bit_lo}), 32'(mseq[k]));
      check("pd", 32'({full_powerdown, fast_powerdown}), 32'({mseq[k] == 0, mseq[k] == 1}));
      check("ticks", 32'(rises - r0), (k < 2) ? 32'(CONV_TICKS) : '0);
      if (k % 2 == 1) check("pd_conv", 32'(pdc - p0), '0);
    end
    check("half_fast", 32'(max_hi), 32'(HALF_FAST));
    $display("test modes done");
    sd_float <= 1'b0;
    settle();
    send(8'h82, 5'd14);
    conv_wait();
    check("half_slow", 32'(max_hi), 32'(HALF_SLOW));
    analog_uv <= 22'd2000000;
    send(8'h82, 5'd14);
    repeat (100) @(posedge ref_clk);
    check("busy", 32'(conv_busy), 32'h1);
    sd_in <= 1'b0;
    repeat (5) @(posedge ref_clk);
    check("abort", 32'({conv_busy, hw_powerdown}), 32'h1);
    send(8'h83, 5'd14);
    repeat (300) @(posedge ref_clk);
    check("refused", 32'({conv_busy, pd_mode_bit_hi, pd_mode_bit_lo}), 32'h2);
    check("held", 32'(result_code), '0);
    $display("test abort done");
    sd_in <= 1'b1;
    sd_float <= 1'b1;
    settle();
    send(8'h81, 5'd14); // Host idles in fast power-down
    conv_wait();
    check("fast_wait", 32'(fast_powerdown), 32'h1);
    send(8'h83, 5'd14); // Dummy conversion after wake
    conv_wait();
    foreach (vals[j])
    begin
      analog_uv <= V_W'(vals[j]);
      repeat (4) @(posedge ref_clk);
      send(8'h83, 5'd14);
      conv_wait();
      e = (longint'(vals[j]) * CODE_STEPS + VREF_UV / 2) / VREF_UV;
      if (e > CODE_STEPS - 1) e = CODE_STEPS - 1;
      check("code", 32'(result_code), 32'(e));
      bus(1'b0, OFS_RESULT, '0);
      check("result_reg", rd, 32'h8000 | 32'(e));
    end
    $display("test coding done");
    tally_and_finish();
  end
endmodule // tb_adc_power_down_clock_control
`default_nettype wire
